// [verilog/rca_top.sv]
// calibration, square wave and alarm logic of the clock block
//
// What this block does
// RULE1: trim-mode bit 1 gives the shared pin wholly to calibration.
// RULE2: calibration drives a 512 Hz wave from the uncorrected timebase.
// RULE3: correction drops pulses when negative, adds pulses when positive.
// RULE4: sign bit 1 means add pulses, sign bit 0 means remove.
// RULE5: 5-bit magnitude sits beside the sign; zero means no correction.
// RULE6: magnitude and sign are writable only while trim mode is on.
// RULE7: clearing trim mode returns the pin to alarm or wave function.
// RULE8: correction is kept on backup power; host reloads after loss.
// RULE9: slow clock: host writes sign 1 and step count, 4.34 ppm steps; the code steps 18 pulses per 64 s, about 4.29 ppm.
// RULE10: fast clock: host writes sign 0 and the same step count.
// RULE11: a match sets the alarm flag and may pull the pin low.
// RULE12: flag and low pin hold until the control register is read.
// RULE13: five fields, each with an ignore bit, 1 excludes the field.
// RULE14: ignore bit is the field register MSB, BCD value below it.
// RULE15: all fields ignored gives one alarm every second.
// RULE16: seconds only per minute, plus minutes per hour, plus hours daily.
// RULE17: alarm output when trim 0, alarm enable 1 and select 1.
// RULE18: matching continues while running from the backup supply.
// RULE19: matcher and flag keep working in calibration mode.
// RULE20: trim 0 and select 0 give a square wave of 1/512/4096/32768 Hz.
// RULE21: no alarm shows on the pin while a wave is driven.
// RULE22: one evaluation and one event per one-second update.
// RULE23: the pin is only pulled low or released, never driven high.
module rca_top (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// register bus
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// timekeeper counter chain
	input  wire logic [7:0]  time_sec,
	input  wire logic [7:0]  time_min,
	input  wire logic [7:0]  time_hour,
	input  wire logic [7:0]  time_date,
	input  wire logic [7:0]  time_month,
	input  wire logic        time_upd,
	output logic             sec_tick,
	// supply status pin
	input  wire logic        backup_supply,
	// shared open-drain pin
	output logic             shared_open_drain_out,
	output logic             shared_open_drain_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic            trim_en;
	logic            alarm_enable;
	logic            alarm_flag;
	logic            correction_sign;
	logic [4:0]      corr_mag;
	logic            match_or_wave_select;
	logic            wave_rate_select_high;
	logic            wave_rate_select_low;
	logic [4:0][7:0] alm;
	logic            bs_q1;
	logic            bs_q2;
	logic [31:0]     next_rdata;
	logic            next_oe;
	logic            sq_wave;
	logic            cal_wave;
	logic [15:0]     sq_cnt;
	logic            match;
	logic            bus_req;
	logic            bus_done;
	logic            wr_ok;
	logic            rd_ok;
	logic            alm_sel;
	logic [2:0]      alm_idx;
	logic [7:0]      alm_off;

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	rca_timebase u_tb (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.corr_sign (correction_sign),
		.corr_mag  (corr_mag),
		.cal_wave  (cal_wave),
		.sq_cnt    (sq_cnt),
		.sec_tick  (sec_tick),
		.raw_tick  (),
		.pend      ()
	);

	// matcher runs from reset alone, whatever the supply [RULE18]
	rca_alarm_match u_match (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.time_upd (time_upd),
		.cur_time ({time_month, time_date, time_hour, time_min,
			time_sec}),
		.alm      (alm),
		.match    (match)
	);

	// ------------------------------------------------------------
	// supply status pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bs_q1 <= 1'b0;
			bs_q2 <= 1'b0;
		end else begin
			bs_q1 <= backup_supply;
			bs_q2 <= bs_q1;
		end
	end

	// ------------------------------------------------------------
	// bus slave: one wait cycle, then the answer
	// ------------------------------------------------------------
	assign bus_req  = avs_read || avs_write;
	assign bus_done = bus_req && !avs_waitrequest;
	assign wr_ok    = avs_write && bus_done;
	assign rd_ok    = avs_read && bus_done;
	assign alm_off  = avs_address - rca_pkg::OFF_ALM_SEC;
	assign alm_sel  = avs_address >= rca_pkg::OFF_ALM_SEC &&
		avs_address <= rca_pkg::OFF_ALM_MON &&
		avs_address[1:0] == 2'h0;
	assign alm_idx  = alm_off[4:2];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			avs_waitrequest <= 1'b1;
		else if (bus_req && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	always_comb begin
		next_rdata = 32'h0;
		if (alm_sel) begin
			next_rdata[7:0] = alm[alm_idx];
		end else begin
			unique case (avs_address)
				rca_pkg::OFF_CTRL: begin
					next_rdata[rca_pkg::CTRL_FLAG] = alarm_flag;
					next_rdata[rca_pkg::CTRL_AEN]  = alarm_enable;
					next_rdata[rca_pkg::CTRL_TRIM] = trim_en;
				end
				rca_pkg::OFF_CORR: begin
					next_rdata[rca_pkg::CORR_SIGN] = correction_sign;
					next_rdata[4:0]                = corr_mag;
				end
				rca_pkg::OFF_OUT: begin
					next_rdata[rca_pkg::OUT_SEL]      = match_or_wave_select;
					next_rdata[rca_pkg::OUT_RATE + 1] = wave_rate_select_high;
					next_rdata[rca_pkg::OUT_RATE]     = wave_rate_select_low;
				end
				rca_pkg::OFF_STAT: next_rdata[0] = bs_q2;
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			avs_readdata <= 32'h0;
		else if (avs_read && avs_waitrequest)
			avs_readdata <= next_rdata;
	end

	// ------------------------------------------------------------
	// control and output registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			trim_en      <= 1'b0;
			alarm_enable <= 1'b0;
		end else if (wr_ok && avs_address == rca_pkg::OFF_CTRL) begin
			trim_en      <= avs_writedata[rca_pkg::CTRL_TRIM]; // [RULE7]
			alarm_enable <= avs_writedata[rca_pkg::CTRL_AEN];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			match_or_wave_select  <= rca_pkg::RST_OUT[2];
			wave_rate_select_high <= rca_pkg::RST_OUT[1];
			wave_rate_select_low  <= rca_pkg::RST_OUT[0];
		end else if (wr_ok && avs_address == rca_pkg::OFF_OUT) begin
			match_or_wave_select  <= avs_writedata[rca_pkg::OUT_SEL];
			wave_rate_select_high <= avs_writedata[rca_pkg::OUT_RATE + 1];
			wave_rate_select_low  <= avs_writedata[rca_pkg::OUT_RATE];
		end
	end

	// only rstn clears the setting; it stands for loss of backup [RULE8]
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			correction_sign <= rca_pkg::RST_CORR[5];
			corr_mag        <= rca_pkg::RST_CORR[4:0];
		end else if (wr_ok && avs_address == rca_pkg::OFF_CORR &&
			trim_en) begin // [RULE6]
			correction_sign <= avs_writedata[rca_pkg::CORR_SIGN]; // [RULE4]
			corr_mag        <= avs_writedata[4:0]; // [RULE5]
		end
	end

	// ignore bit in the MSB, BCD value below [RULE14]
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 5; i++)
				alm[i] <= rca_pkg::RST_ALM;
		end else if (wr_ok && alm_sel) begin
			alm[alm_idx] <= avs_writedata[7:0]; // [RULE13]
		end
	end

	// ------------------------------------------------------------
	// alarm flag: a match in the clearing cycle wins
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			alarm_flag <= 1'b0;
		else if (match)
			alarm_flag <= 1'b1; // [RULE11] [RULE19]
		else if (rd_ok && avs_address == rca_pkg::OFF_CTRL)
			alarm_flag <= 1'b0; // [RULE12]
	end

	// ------------------------------------------------------------
	// shared pin: low or released, never driven high
	// ------------------------------------------------------------
	always_comb begin
		unique case ({wave_rate_select_high, wave_rate_select_low})
			rca_pkg::RATE_1HZ:  sq_wave = sq_cnt[rca_pkg::WBIT_1HZ];
			rca_pkg::RATE_512:  sq_wave = sq_cnt[rca_pkg::WBIT_512];
			rca_pkg::RATE_4096: sq_wave = sq_cnt[rca_pkg::WBIT_4096];
			rca_pkg::RATE_32K:  sq_wave = sq_cnt[rca_pkg::WBIT_32K];
		endcase
	end

	always_comb begin
		if (trim_en)
			next_oe = !cal_wave; // [RULE1] [RULE2]
		else if (!match_or_wave_select)
			next_oe = !sq_wave; // [RULE20] [RULE21]
		else if (alarm_enable)
			next_oe = alarm_flag; // [RULE17] [RULE11]
		else
			next_oe = 1'b0; // [RULE23]
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shared_open_drain_oe  <= 1'b0;
			shared_open_drain_out <= 1'b0;
		end else begin
			shared_open_drain_oe  <= next_oe;
			shared_open_drain_out <= 1'b0; // [RULE23]
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence req_wait_s;
		bus_req && avs_waitrequest;
	endsequence

	sequence ack_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	bus_answer_a: assert property (req_wait_s |=> ack_s)
		else $error("bus answer not after one wait cycle");

	cal_pin_a: assert property ( // [RULE1]
		trim_en |=> shared_open_drain_oe == !$past(cal_wave))
		else $error("pin not carrying calibration wave");

	corr_lock_a: assert property ( // [RULE6]
		$changed(corr_mag) |-> $past(wr_ok && trim_en))
		else $error("correction changed outside trim mode");

	flag_set_a: assert property (match |=> alarm_flag) // [RULE11]
		else $error("alarm flag not set by match");

	flag_hold_a: assert property ( // [RULE12]
		(alarm_flag && !(rd_ok && avs_address == rca_pkg::OFF_CTRL)) |=>
		alarm_flag) else $error("alarm flag lost before control read");

	flag_clear_a: assert property ( // [RULE12]
		(rd_ok && avs_address == rca_pkg::OFF_CTRL && !match) |=>
		!alarm_flag) else $error("control read did not clear flag");

	alarm_pin_a: assert property ( // [RULE17]
		(!trim_en && alarm_enable && match_or_wave_select &&
		alarm_flag) |=> shared_open_drain_oe)
		else $error("alarm not pulling pin low");

	wave_pin_a: assert property ( // [RULE21]
		(!trim_en && !match_or_wave_select) |=>
		shared_open_drain_oe == !$past(sq_wave))
		else $error("wave disturbed on pin");

	pin_release_a: assert property ( // [RULE23]
		(!trim_en && match_or_wave_select &&
		!(alarm_enable && alarm_flag)) |=> !shared_open_drain_oe)
		else $error("pin held low with nothing asking");

	never_high_a: assert property (!shared_open_drain_out) // [RULE23]
		else $error("pin driven high");

	cal_flag_a: assert property ( // [RULE19]
		(trim_en && match) |=> alarm_flag)
		else $error("flag lost in calibration mode");

endmodule // rca_top

// [verilog/rca_pkg.sv]
// constants shared by the calibration and alarm block
package rca_pkg;

	// ------------------------------------------------------------
	// clocks and timebase
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ    = 250_000_000;
	localparam int unsigned CLK_NS    = 4;
	// two ticks per crystal cycle so that 32768 Hz can be shown
	localparam int unsigned TB_HZ     = 65536;
	localparam logic [27:0] TB_INC    = 28'(TB_HZ);
	localparam logic [27:0] TB_MOD    = 28'(CLK_HZ);

	// counter bit that toggles at each wave rate
	localparam int unsigned WBIT_1HZ  = 15;
	localparam int unsigned WBIT_512  = 6;
	localparam int unsigned WBIT_4096 = 3;
	localparam int unsigned WBIT_32K  = 0;

	// rate select codes
	localparam logic [1:0]  RATE_1HZ  = 2'h0;
	localparam logic [1:0]  RATE_512  = 2'h1;
	localparam logic [1:0]  RATE_4096 = 2'h2;
	localparam logic [1:0]  RATE_32K  = 2'h3;

	// ------------------------------------------------------------
	// correction: step pulses per period, about 4.3 ppm a step
	// ------------------------------------------------------------
	localparam logic [5:0]  CORR_PERIOD_S = 6'h3f;
	localparam logic [9:0]  CORR_STEP     = 10'h012;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_CORR    = 8'h04;
	localparam logic [7:0]  OFF_OUT     = 8'h08;
	localparam logic [7:0]  OFF_ALM_SEC = 8'h0c;
	localparam logic [7:0]  OFF_ALM_MON = 8'h1c;
	localparam logic [7:0]  OFF_STAT    = 8'h20;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_FLAG   = 6;
	localparam int unsigned CTRL_AEN    = 3;
	localparam int unsigned CTRL_TRIM   = 2;
	localparam int unsigned CORR_SIGN   = 5;
	localparam int unsigned OUT_SEL     = 7;
	localparam int unsigned OUT_RATE    = 5;
	localparam int unsigned ALM_IGN     = 7;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [5:0]  RST_CORR    = 6'h00;
	localparam logic [2:0]  RST_OUT     = 3'h4;
	localparam logic [7:0]  RST_ALM     = 8'h80;

endpackage

// [verilog/rca_timebase.sv]
// timebase divider with digital pulse add/drop correction
module rca_timebase (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// correction setting
	input  wire logic        corr_sign,
	input  wire logic [4:0]  corr_mag,
	// timebase outputs
	output logic             cal_wave,
	output logic [15:0]      sq_cnt,
	output logic             sec_tick,
	// pulse activity, visible for checking
	output logic             raw_tick,
	output logic [9:0]       pend
);
	logic [27:0] acc;
	logic [6:0]  raw_cnt;
	logic [5:0]  per_cnt;
	logic        add_now;
	logic        drop_now;
	logic        ctick;

	// fractional divider keeps the long-term rate exact
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			acc      <= 28'h0;
			raw_tick <= 1'b0;
		end else if (acc + rca_pkg::TB_INC >= rca_pkg::TB_MOD) begin
			acc      <= acc + rca_pkg::TB_INC - rca_pkg::TB_MOD;
			raw_tick <= 1'b1;
		end else begin
			acc      <= acc + rca_pkg::TB_INC;
			raw_tick <= 1'b0;
		end
	end

	// reference counts raw ticks, untouched by correction [RULE2]
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			raw_cnt <= 7'h0;
		else if (raw_tick)
			raw_cnt <= raw_cnt + 7'h1;
	end
	assign cal_wave = raw_cnt[rca_pkg::WBIT_512]; // [RULE2]

	// sign 1 inserts pulses, sign 0 swallows them [RULE3] [RULE4]
	assign add_now  = (pend != 10'h0) && corr_sign && !raw_tick;
	assign drop_now = (pend != 10'h0) && !corr_sign && raw_tick;
	assign ctick    = (raw_tick && !drop_now) || add_now;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sq_cnt   <= 16'h0;
			sec_tick <= 1'b0;
		end else begin
			if (ctick)
				sq_cnt <= sq_cnt + 16'h1;
			sec_tick <= ctick && (sq_cnt == 16'hffff);
		end
	end

	// magnitude zero loads nothing, so no correction [RULE5]
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			per_cnt <= 6'h0;
			pend    <= 10'h0;
		end else if (sec_tick && per_cnt == rca_pkg::CORR_PERIOD_S) begin
			per_cnt <= 6'h0;
			pend    <= 10'(corr_mag) * rca_pkg::CORR_STEP; // [RULE3]
		end else begin
			if (sec_tick)
				per_cnt <= per_cnt + 6'h1;
			if (add_now || drop_now)
				pend <= pend - 10'h1;
		end
	end

	drop_tick_a: assert property ( // [RULE4]
		@(posedge ref_clk) disable iff (!rstn)
		(pend != 10'h0 && !corr_sign && raw_tick) |=>
		$stable(sq_cnt)) else $error("dropped pulse still counted");

endmodule // rca_timebase

// [verilog/rca_alarm_match.sv]
// masked comparison of five alarm fields against the time
module rca_alarm_match (
	// clock and reset
	input  wire logic            ref_clk,
	input  wire logic            rstn,
	// time update strobe and fields: sec, min, hour, date, month
	input  wire logic            time_upd,
	input  wire logic [4:0][7:0] cur_time,
	input  wire logic [4:0][7:0] alm,
	// one pulse per matching update
	output logic                 match
);
	logic [4:0] hit;

	// ignore bit set excludes the field [RULE13] [RULE14]
	for (genvar i = 0; i < 5; i++) begin : g_field
		assign hit[i] = alm[i][rca_pkg::ALM_IGN] ||
			(alm[i][6:0] == cur_time[i][6:0]);
	end

	// evaluated once per update, so one event per second at most
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			match <= 1'b0;
		else
			match <= time_upd && (&hit); // [RULE22] [RULE15] [RULE16]
	end

	all_ign_a: assert property ( // [RULE15]
		@(posedge ref_clk) disable iff (!rstn)
		(time_upd && (&{alm[0][7], alm[1][7], alm[2][7], alm[3][7],
		alm[4][7]})) |=> match) else $error("no alarm each second");

	one_shot_a: assert property ( // [RULE22]
		@(posedge ref_clk) disable iff (!rstn)
		match |-> $past(time_upd)) else $error("match without update");

endmodule // rca_alarm_match

// [tb/rca_host_model.sv]
// host side of the shared open-drain pin: pull-up and line sensing
module rca_host_model (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// shared open-drain pin as split by the device
	input  wire logic shared_open_drain_out,
	input  wire logic shared_open_drain_oe,
	// resolved line level and count of illegal high drives
	output logic      pin_level,
	output int        high_drive_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------
	// the pull-up wins whenever the device lets go of the line
	assign pin_level = shared_open_drain_oe ? shared_open_drain_out : 1'b1;

	// ------------------------------------------------------------
	// line monitor
	// ------------------------------------------------------------
	// an open-drain driver may only pull low; anything else fights the pull-up
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			high_drive_cnt <= 0;
		else if (shared_open_drain_oe && shared_open_drain_out !== 1'b0)
			high_drive_cnt <= high_drive_cnt + 1;
	end
endmodule // rca_host_model

// [tb/tb_rtc_calibration_and_alarm.sv]
// self-checking bench for the calibration, wave and alarm block
module tb_rtc_calibration_and_alarm;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [4:0][7:0] AV = {8'h11, 8'h21, 8'h08, 8'h15, 8'h30};
	logic            ref_clk       = 1'b0;
	logic            rstn          = 1'b0;
	logic [7:0]      avs_address   = 8'h00;
	logic            avs_read      = 1'b0;
	logic            avs_write     = 1'b0;
	logic [31:0]     avs_writedata = 32'h0;
	logic [31:0]     avs_readdata;
	logic            avs_waitrequest;
	logic [4:0][7:0] tv            = '0;
	logic            time_upd      = 1'b0;
	logic            sec_tick;
	logic            backup_supply = 1'b0;
	logic            od_out;
	logic            od_oe;
	logic            pin_level;
	int              hd_cnt;
	int              miscompares   = 0;
	int              cmp_count     = 0;

	initial forever #2 ref_clk = ~ref_clk;

	rca_top DUT (
		.ref_clk(ref_clk), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.time_sec(tv[0]), .time_min(tv[1]), .time_hour(tv[2]),
		.time_date(tv[3]), .time_month(tv[4]), .time_upd(time_upd),
		.sec_tick(sec_tick), .backup_supply(backup_supply),
		.shared_open_drain_out(od_out), .shared_open_drain_oe(od_oe)
	);

	rca_host_model host (
		.ref_clk(ref_clk), .rstn(rstn),
		.shared_open_drain_out(od_out), .shared_open_drain_oe(od_oe),
		.pin_level(pin_level), .high_drive_cnt(hd_cnt)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
	endtask

	// one access; the extra edge keeps requests from re-rising in one step
	task automatic bus(input logic wr_en, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr_en;
		avs_read      <= !wr_en;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge ref_clk);
		if (n >= 50) begin
			miscompares++;
			$display("MISMATCH bus answer expected 0 seen timeout");
			finish_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, q);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a,
			input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(what, exp, q);
	endtask

	task automatic upd(input logic [4:0][7:0] t);
		tv       <= t;
		time_upd <= 1'b1;
		@(posedge ref_clk);
		time_upd <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// cycles between two pin edges; lim means no edge was seen
	task automatic edge_gap(input int lim, output int gap);
		logic p;
		int   n;
		repeat (4) @(posedge ref_clk);
		p = pin_level;
		n = 0;
		while (pin_level === p && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		p   = pin_level;
		gap = 0;
		while (pin_level === p && gap < lim) begin
			@(posedge ref_clk);
			gap++;
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		int i;
		check("oe idle", 32'h0, 32'(od_oe));
		check("sec tick idle", 32'h0, 32'(sec_tick));
		rd_chk("stat", rca_pkg::OFF_STAT, 32'h0);
		rd_chk("ctrl", rca_pkg::OFF_CTRL, 32'h0);
		rd_chk("corr", rca_pkg::OFF_CORR, 32'h0);
		rd_chk("out", rca_pkg::OFF_OUT, 32'h80);
		for (i = 0; i < 5; i++)
			rd_chk("alm", rca_pkg::OFF_ALM_SEC + 8'(4 * i), 32'h80);
		rd_chk("unmapped", 8'h24, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_corr;
		wr(rca_pkg::OFF_CORR, 8'h21);
		rd_chk("corr locked", rca_pkg::OFF_CORR, 32'h0);
		wr(rca_pkg::OFF_CTRL, 8'h04);
		wr(rca_pkg::OFF_CORR, 8'h21); // slow clock, one step
		rd_chk("corr add", rca_pkg::OFF_CORR, 32'h21);
		wr(rca_pkg::OFF_CORR, 8'h1f); // fast clock, top step
		rd_chk("corr drop", rca_pkg::OFF_CORR, 32'h1f);
		wr(rca_pkg::OFF_CTRL, 8'h00);
		wr(rca_pkg::OFF_CORR, 8'h00);
		rd_chk("corr kept", rca_pkg::OFF_CORR, 32'h1f);
		$display("test correction done");
	endtask

	task automatic t_alarm;
		logic [4:0][7:0] t;
		int              i;
		backup_supply <= 1'b1;
		wr(rca_pkg::OFF_CTRL, 8'h08);
		rd_chk("backup", rca_pkg::OFF_STAT, 32'h1);
		for (i = 0; i < 2; i++) begin
			upd(AV);
			check("pin set", 32'h0, 32'(pin_level));
			repeat (20) @(posedge ref_clk);
			check("pin held", 32'h0, 32'(pin_level));
			rd_chk("flag", rca_pkg::OFF_CTRL, 32'h48);
			repeat (3) @(posedge ref_clk);
			check("pin free", 32'h1, 32'(pin_level));
			rd_chk("flag clr", rca_pkg::OFF_CTRL, 32'h08);
		end
		for (i = 0; i < 5; i++) begin
			wr(rca_pkg::OFF_ALM_SEC + 8'(4 * i), AV[i]);
			rd_chk("alm", rca_pkg::OFF_ALM_SEC + 8'(4 * i), 32'(AV[i]));
			t    = AV;
			t[i] = AV[i] ^ 8'h01;
			upd(t);
			rd_chk("no match", rca_pkg::OFF_CTRL, 32'h08);
			upd(AV);
			check("pin match", 32'h0, 32'(pin_level));
			rd_chk("match", rca_pkg::OFF_CTRL, 32'h48);
		end
		for (i = 0; i < 5; i++)
			wr(rca_pkg::OFF_ALM_SEC + 8'(4 * i), 8'h80);
		backup_supply <= 1'b0;
		$display("test alarm done");
	endtask

	task automatic t_wave;
		int g;
		wr(rca_pkg::OFF_OUT, 8'h60);
		upd(AV);
		edge_gap(4000, g);
		check("gap 32768", 32'h1, 32'(g inside {[3814:3815]}));
		rd_chk("wave flag", rca_pkg::OFF_CTRL, 32'h48);
		wr(rca_pkg::OFF_OUT, 8'h40);
		edge_gap(31000, g);
		check("gap 4096", 32'h1, 32'(g inside {[30517:30518]}));
		wr(rca_pkg::OFF_OUT, 8'h00);
		edge_gap(2000, g);
		check("1 Hz steady", 32'd2000, 32'(g));
		wr(rca_pkg::OFF_OUT, 8'h20);
		edge_gap(2000, g);
		check("512 Hz steady", 32'd2000, 32'(g));
		wr(rca_pkg::OFF_OUT, 8'h80);
		$display("test wave done");
	endtask

	task automatic t_cal;
		int   g;
		logic p;
		wr(rca_pkg::OFF_CTRL, 8'h0c);
		edge_gap(2000, g);
		check("cal steady", 32'd2000, 32'(g));
		p = pin_level;
		upd(AV);
		check("cal pin", 32'(p), 32'(pin_level));
		wr(rca_pkg::OFF_CTRL, 8'h08); // host leaves calibration
		repeat (3) @(posedge ref_clk);
		check("alarm back", 32'h0, 32'(pin_level));
		rd_chk("cal flag", rca_pkg::OFF_CTRL, 32'h48);
		repeat (3) @(posedge ref_clk);
		check("cal free", 32'h1, 32'(pin_level));
		$display("test calibration done");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		t_reset();
		t_corr();
		t_alarm();
		t_wave();
		t_cal();
		check("drive high", 32'h0, 32'(hd_cnt));
		do_reset();
		rd_chk("corr lost", rca_pkg::OFF_CORR, 32'h0);
		finish_test();
	end
endmodule // tb_rtc_calibration_and_alarm
